// *** dv/chc_assertions.sv ***
// Purpose: Port-level checks of the channel clock and mode block.
// Assumes: One clock domain; run outputs lag the register image by one edge.
// Notes: Bound to every instance of the top module.
`timescale 1ns/100ps
`default_nettype none
module chc_assertions
(
    input wire logic                  CLK,
    input wire logic                  RESETN,
    input wire chc_pkg::chc_axi_req_t AXI_REQ,
    input wire chc_pkg::chc_axi_rsp_t AXI_RSP,
    input wire logic                  TX_DATA,
    input wire logic                  TXD_O,
    input wire logic                  TXD_OE_N,
    input wire logic                  CTS_N,
    input wire logic                  CD_N,
    input wire logic [15:0]           TXBD_STATUS,
    input wire logic [15:0]           RXBD_STATUS,
    input wire logic                  RX_FRAME_END,
    input wire logic [15:0]           MODE_CFG,
    input wire logic                  BYTE_SYNC,
    input wire logic                  TX_RUN,
    input wire logic                  RX_RUN,
    input wire logic                  RX_IDLE_FILL
);
    import chc_pkg::*;

    // All checks share the main clock and its reset.
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN);

    // Bus transfer steps.
    sequence s_wr_take;
        AXI_REQ.awvalid && AXI_RSP.awready && AXI_REQ.wvalid && AXI_RSP.wready;
    endsequence
    sequence s_rd_take;
        AXI_REQ.arvalid && AXI_RSP.arready;
    endsequence
    sequence s_rd_bad;
        s_rd_take ##0 (AXI_REQ.araddr[2:0] != 3'h0 || AXI_REQ.araddr < 16'h2208
            || AXI_REQ.araddr > 16'h2238);
    endsequence

    a_od_release: assert property (TXD_OE_N |-> !TXD_O && $past(TX_DATA))
        else $error("open-drain pin released while data low");
    a_mode_rsvd: assert property (MODE_CFG[9] == 1'b0)
        else $error("reserved mode bit set");
    a_sync_mode: assert property (BYTE_SYNC |-> $past(MODE_CFG[1:0]) == MODE_TRANSP)
        else $error("byte sync without protocol mode 3");
    a_tx_gate: assert property (TX_RUN |-> $past(MODE_CFG[MC_TE]) && $past(TXBD_STATUS[BD_RDY])
        && ($past(MODE_CFG[5:4]) != LOOP_AUTO || !$past(CTS_N)))
        else $error("transmit runs without enable, ready or clear-to-send");
    a_rx_gate: assert property (RX_RUN |-> $past(MODE_CFG[MC_RE]) && $past(RXBD_STATUS[BD_RDY])
        && ($past(MODE_CFG[5:4]) != LOOP_AUTO || !$past(CD_N)))
        else $error("receive runs without enable, empty or carrier");
    a_idle_cause: assert property (RX_IDLE_FILL |-> $past(MODE_CFG[MC_RE])
        && $past(RXBD_STATUS[BD_RDY]) && $past(MODE_CFG[1:0]) == MODE_TRANSP)
        else $error("idle fill outside transparent receive");
    a_wr_answer: assert property (s_wr_take |-> ##[1:2] AXI_RSP.bvalid)
        else $error("write response missing");
    a_rd_answer: assert property (s_rd_take |=> AXI_RSP.rvalid)
        else $error("read response missing");
    a_rd_unmapped: assert property (s_rd_bad |=> AXI_RSP.rresp == RSP_ERR)
        else $error("unmapped read not refused");
endmodule // chc_assertions

bind chc_top chc_assertions chk_u (.CLK, .RESETN, .AXI_REQ, .AXI_RSP, .TX_DATA, .TXD_O,
    .TXD_OE_N, .CTS_N, .CD_N, .TXBD_STATUS, .RXBD_STATUS, .RX_FRAME_END, .MODE_CFG,
    .BYTE_SYNC, .TX_RUN, .RX_RUN, .RX_IDLE_FILL);
`default_nettype wire

// *** dv/chc_far_model.sv ***
// Purpose: Serial line peer with external clock pins for the channel block.
// Assumes: Pin clocks are slow multiples of the main clock.
// Notes: Pin clocks stand still while no frame is running.
`timescale 1ns/100ps
`default_nettype none
module chc_far_model
(
    input  wire logic clk,
    input  wire logic run,
    input  wire logic txd_o,
    input  wire logic txd_oe_n,
    output logic      timer_in,
    output logic      transmit_clock_pin,
    output logic      rclk,
    output logic      line
);
    int n;

    // A pull-up holds the line high whenever the driver lets go.
    assign line = txd_oe_n ? 1'b1 : txd_o;

    // Timer rises every 4 cycles, transmit pin toggles every 3, receive pin every 5.
    initial
    begin
        n = 0;
        timer_in = 1'b0;
        transmit_clock_pin = 1'b0;
        rclk = 1'b0;
    end
    always @(posedge clk)
    begin
        if (run)
        begin
            n <= n + 1;
            if (n % 2 == 1) timer_in <= ~timer_in;
            if (n % 3 == 2) transmit_clock_pin <= ~transmit_clock_pin;
            if (n % 5 == 4) rclk <= ~rclk;
        end
    end
endmodule // chc_far_model
`default_nettype wire

// *** dv/testbench.sv ***
// Purpose: Self-checking bench of the channel clock and mode block.
// Assumes: Register model mirrors every readable register except status.
// Notes: Bus answers are sampled on the falling edge and taken at the next rise.
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import chc_pkg::*;

    chc_axi_req_t req;
    chc_axi_rsp_t rsp;
    logic CLK, RESETN, tmr, tpin, rpin, tx_data, txd_i, cts_n, cd_n, dedi, run;
    logic frame_end, txbd_done, rxbd_done, brg, txclk, rxclk, bsync, txrun, rxrun, idle, irq;
    logic txd_o, txd_oe_n, stopbit, tx_err, rxfull;
    logic [2:0] clks;
    logic [7:0] evt_in;
    logic [15:0] txbd_st, rxbd_st, rx_cnt, lf, mode_cfg;
    logic [31:0] mdl [7];
    int fails, cmp_count;
    int ri[4] = '{0, 1, 3, 5};
    logic [15:0] cfg[6] = '{16'h0000, 16'h0005, 16'h4002, 16'h3000, 16'h3000, 16'h0000};
    int sel[6] = '{0, 0, 0, 1, 2, 1};
    int per[6] = '{1, 12, 8, 3, 5, 1};

    chc_top dut_u (.CLK(CLK), .RESETN(RESETN), .AXI_REQ(req), .AXI_RSP(rsp),
        .TIMER_ONE_INPUT(tmr), .TRANSMIT_CLOCK_PIN(tpin), .RECEIVE_CLOCK_PIN(rpin),
        .TX_DATA(tx_data), .TXD_I(txd_i), .TXD_O(txd_o), .TXD_OE_N(txd_oe_n), .CTS_N(cts_n),
        .CD_N(cd_n), .MODEM_DEDICATED(dedi), .EVT_IN(evt_in), .TXBD_STATUS(txbd_st),
        .TXBD_DONE(txbd_done), .TX_ERROR(tx_err), .RXBD_STATUS(rxbd_st), .RXBD_DONE(rxbd_done),
        .RX_FRAME_END(frame_end), .RX_BYTE_CNT(rx_cnt), .BRG_OUT(brg), .TX_CLK(txclk),
        .RX_CLK(rxclk), .MODE_CFG(mode_cfg), .BYTE_SYNC(bsync), .TX_RUN(txrun),
        .RX_RUN(rxrun), .RX_BUF_FULL(rxfull), .RX_IDLE_FILL(idle), .IRQ(irq));
    chc_far_model far_u (.clk(CLK), .run(run), .txd_o(txd_o), .txd_oe_n(txd_oe_n),
        .timer_in(tmr), .transmit_clock_pin(tpin), .rclk(rpin), .line(txd_i));

    // Clock outputs gathered so that a scenario can pick one by index.
    assign clks = {rxclk, txclk, brg};

    // Free-running main clock.
    initial
    begin
        CLK = 1'b0;
        forever #2.5 CLK = ~CLK;
    end

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input logic [33:0] e, input logic [33:0] g);
        cmp_count++;
        if (g !== e)
        begin
            $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
            fails++;
        end
    endtask

    task automatic guard(input bit ok);
        if (!ok)
        begin
            fails++;
            stop_test();
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge CLK);
    endtask

    // One AXI4-Lite transfer; entered and left just after a rising edge.
    task automatic bus(input bit wr, input logic [15:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic [1:0] r);
        int n;
        logic h1, h2, h3;
        n = 0;
        h3 = 1'b0;
        req.awvalid <= wr;
        req.wvalid <= wr;
        req.bready <= wr;
        req.arvalid <= !wr;
        req.rready <= !wr;
        req.awaddr <= a;
        req.araddr <= a;
        req.wdata <= d;
        while (!h3 && n < 50)
        begin
            @(negedge CLK);
            h1 = wr ? rsp.awready : rsp.arready;
            h2 = rsp.wready;
            h3 = wr ? rsp.bvalid : rsp.rvalid;
            q = rsp.rdata;
            r = wr ? rsp.bresp : rsp.rresp;
            @(posedge CLK);
            n++;
            if (wr && h1) req.awvalid <= 1'b0;
            if (wr && h2) req.wvalid <= 1'b0;
            if (!wr && h1) req.arvalid <= 1'b0;
        end
        req.bready <= 1'b0;
        req.rready <= 1'b0;
        @(posedge CLK);
        guard(h3);
    endtask

    // Register write that also updates the model.
    task automatic wr(input int i, input logic [31:0] d);
        logic [31:0] q;
        logic [1:0] r;
        bus(1'b1, 16'h2208 + 16'(i * 8), d, q, r);
        chk({RSP_OK, 32'h0}, {r, 32'h0});
        case (i)
            1: mdl[1] = d & 32'(MC_WMASK);
            2: mdl[2] = mdl[2] & ~d & 32'hFF;
            3: mdl[3] = d & 32'hFF;
            4: begin stopbit = d[1] | (stopbit & ~d[2]); mdl[4] = {29'h0, stopbit, 1'b0, d[0]}; end
            default: mdl[i] = d & 32'hFFFF;
        endcase
    endtask

    task automatic rd(input int i);
        logic [31:0] q;
        logic [1:0] r;
        bus(1'b0, 16'h2208 + 16'(i * 8), 32'h0, q, r);
        chk({RSP_OK, mdl[i]}, {r, q});
    endtask

    task automatic pulse(input logic [7:0] v);
        evt_in <= v;
        tick(1);
        evt_in <= 8'h00;
        mdl[2] = mdl[2] | 32'(v);
        tick(1);
    endtask

    // Counts cycles between two changes of a selected clock output.
    task automatic period(input int s, input int e);
        int n;
        logic o;
        n = 0;
        @(negedge CLK);
        o = clks[s];
        while (clks[s] === o && n < 200)
        begin
            @(negedge CLK);
            n++;
        end
        o = clks[s];
        n = 0;
        while (clks[s] === o && n < 200)
        begin
            @(negedge CLK);
            n++;
        end
        @(posedge CLK);
        guard(n < 200);
        chk(34'(e), 34'(n));
    endtask

    // Main sequence.
    initial
    begin : main
        logic [31:0] q;
        logic [1:0] r;
        req = '0;
        req.wstrb = 4'hF;
        {RESETN, tx_data, dedi, run, frame_end, txbd_done, rxbd_done, stopbit, tx_err} = '0;
        {cts_n, cd_n} = 2'b11;
        {evt_in, txbd_st, rxbd_st, rx_cnt, fails, cmp_count} = '0;
        lf = 16'd35;
        foreach (mdl[i]) mdl[i] = 32'h0;
        tick(4);
        RESETN <= 1'b1;
        tick(1);
        for (int i = 0; i < 6; i++) rd(i);
        bus(1'b0, 16'h2240, 32'h0, q, r);
        chk(34'(RSP_ERR), 34'(r));
        bus(1'b1, 16'h220C, 32'hFFFF, q, r);
        chk(34'(RSP_ERR), 34'(r));
        for (int k = 0; k < 3; k++)
            foreach (ri[j])
            begin
                lf = lfsr(lf);
                tx_data <= lf[0];
                rx_cnt <= lf;
                wr(ri[j], (ri[j] == 1) ? 32'(lf & MC_WMASK) : 32'(lf));
                rd(ri[j]);
                chk(34'(rx_cnt >= mdl[5][15:0]), 34'(rxfull));
            end
        wr(1, 0);
        wr(4, 0);
        wr(3, 0);
        pulse(8'hFF);
        tick(2);
        chk(34'(0), 34'(irq));
        rd(2);
        wr(3, 32'h02);
        tick(2);
        chk(34'(1), 34'(irq));
        rd(2);
        wr(2, 32'hFF);
        tick(2);
        chk(34'(0), 34'(irq));
        pulse(8'hA5);
        wr(2, 32'h05);
        rd(2);
        wr(1, 32'h3);
        wr(4, 32'h1);
        wr(3, 32'h28);
        pulse(8'h28);
        tick(2);
        chk(34'(0), 34'({irq, bsync}));
        wr(4, 0);
        tick(2);
        chk(34'(3), 34'({irq, bsync}));
        wr(3, 0);
        for (int k = 0; k < 2; k++)
        begin
            wr(2, 32'hFF);
            txbd_st <= k ? 16'hD800 : 16'h8000;
            rxbd_st <= k ? 16'hD000 : 16'h8000;
            tick(1);
            {txbd_done, rxbd_done} <= 2'b11;
            tick(1);
            {txbd_done, rxbd_done} <= 2'b00;
            mdl[2] = k ? 32'h3 : 32'h0;
            tick(1);
            rd(2);
        end
        {cts_n, cd_n} <= 2'b00;
        wr(1, 32'h000C);
        tick(2);
        chk(34'(3), 34'({txrun, rxrun}));
        wr(4, 32'h2);
        tick(2);
        chk(34'(0), 34'(txrun));
        rd(4);
        wr(4, 32'h4);
        tick(2);
        chk(34'(1), 34'(txrun));
        rd(4);
        tx_err <= 1'b1;
        tick(1);
        tx_err <= 1'b0;
        stopbit = 1'b1;
        mdl[4] = 32'h4;
        rd(4);
        wr(4, 32'h4);
        tick(2);
        chk(34'(1), 34'(txrun));
        cts_n <= 1'b1;
        tick(2);
        chk(34'(0), 34'(txrun));
        wr(1, 32'h001C);
        tick(2);
        chk(34'(1), 34'(txrun));
        wr(1, 32'h001F);
        wr(4, 32'h1);
        frame_end <= 1'b1;
        tick(1);
        frame_end <= 1'b0;
        tick(2);
        chk(34'(1), 34'(idle));
        wr(1, 0);
        tick(2);
        chk(34'(0), 34'(idle));
        dedi <= 1'b1;
        wr(2, 32'hFF);
        cd_n <= 1'b1;
        tick(3);
        mdl[2] = 32'h80;
        rd(2);
        for (int k = 0; k < 4; k++)
        begin
            wr(0, {16'h0, k[1], 15'h0});
            tx_data <= k[0];
            tick(2);
            chk(k[1] ? 34'({1'b0, k[0]}) : 34'({k[0], 1'b0}), 34'({txd_o, txd_oe_n}));
        end
        run <= 1'b1;
        for (int k = 0; k < 6; k++)
        begin
            wr(0, 32'(cfg[k]));
            tick(k ? 30 : 2100);
            period(sel[k], per[k]);
        end
        run <= 1'b0;
        stop_test();
    end
endmodule // testbench
`default_nettype wire

// *** rtl/chc_pkg.sv ***
// Purpose: Shared constants and carriers for the channel clock and mode block.
// Assumes: AXI4-Lite with 16-bit byte addresses and 32-bit data.
// Notes: Register indices times four give the byte address.
package chc_pkg;
    localparam int AW = 16;
    localparam logic [11:0] IDX_CLK = 12'h882;
    localparam logic [11:0] IDX_MODE = 12'h884;
    localparam logic [11:0] IDX_EVT = 12'h886;
    localparam logic [11:0] IDX_MSK = 12'h888;
    localparam logic [11:0] IDX_CTL = 12'h88A;
    localparam logic [11:0] IDX_RXL = 12'h88C;
    localparam logic [11:0] IDX_STA = 12'h88E;
    localparam int CC_OD = 15;
    localparam int CC_EXT = 14;
    localparam int CC_TCS = 13;
    localparam int CC_RCS = 12;
    localparam int CC_CDH = 11;
    localparam int CC_CDL = 1;
    localparam int CC_PRESCALER_SELECT = 0;
    localparam int MC_RE = 3;
    localparam int MC_TE = 2;
    localparam logic [15:0] MC_WMASK = 16'hFDFF;
    localparam logic [1:0] MODE_TRANSP = 2'h3;
    localparam logic [1:0] LOOP_AUTO = 2'h0;
    localparam int CT_NTS = 0;
    localparam int CT_STOP = 1;
    localparam int CT_RESTART = 2;
    localparam int EV_RX = 0;
    localparam int EV_TX = 1;
    localparam int EV_BS = 3;
    localparam int EV_T5 = 5;
    localparam int EV_CTS = 6;
    localparam int EV_CD = 7;
    localparam int BD_RDY = 15;
    localparam int BD_INT = 12;
    localparam logic [1:0] PRE_LAST = 2'h3;
    localparam logic [15:0] RST_REG16 = 16'h0000;
    localparam logic [7:0] RST_REG8 = 8'h00;
    localparam logic [1:0] RSP_OK = 2'h0;
    localparam logic [1:0] RSP_ERR = 2'h2;

    typedef struct packed {
        logic          awvalid;
        logic [AW-1:0] awaddr;
        logic          wvalid;
        logic [31:0]   wdata;
        logic [3:0]    wstrb;
        logic          bready;
        logic          arvalid;
        logic [AW-1:0] araddr;
        logic          rready;
    } chc_axi_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } chc_axi_rsp_t;

    localparam chc_axi_rsp_t RSP_RESET =
        '{awready: 1'b1, wready: 1'b1, arready: 1'b1, default: '0};
endpackage

// *** rtl/chc_top.sv ***
// Purpose: Channel clock selection, baud generator, mode fields and events.
// Assumes: All pin inputs are synchronous to CLK.
// Notes: Registers sit in the low half of each 32-bit word; event, mask and status are 8 bits wide.
// Functional notes
// R1 - Open-drain select makes transmit data open-drain.
// R2 - Bit 14 picks main clock or timer input.
// R3 - Bit 13 picks generator or pin transmit clock.
// R4 - Bit 12 picks generator or pin receive clock.
// R5 - Preset field loads the eleven-bit divider counter.
// R6 - Prescaler divides by one or by four.
// R7 - Mode register holds the listed field layout.
// R8 - Software writes zeros to reserved bits.
// R9 - Writing one clears event bits.
// R10 - Events always recorded; mask gates interrupt.
// R11 - Handler reads, clears, services, then returns.
// R12 - Mask bits five and three ignored in transparent.
// R13 - Ready interrupt descriptor sets transmit event.
// R14 - Receive event on fill; idle fill after frame.
// R15 - Receive length limit bounds only receive buffers.
// R16 - Clearing no-sync bit selects byte-synchronous protocol.
// R17 - Loop control sets automatic modem input gating.
// R18 - Dedicated modem input change raises event.
// R19 - Counter expiry reloads and toggles generator output.
// R20 - Restart resumes transmission after stop or error.
`timescale 1ns/100ps
`default_nettype none
module chc_top
(
    input  wire logic                  CLK,
    input  wire logic                  RESETN,
    input  wire chc_pkg::chc_axi_req_t AXI_REQ,
    output var  chc_pkg::chc_axi_rsp_t AXI_RSP,
    input  wire logic                  TIMER_ONE_INPUT,
    input  wire logic                  TRANSMIT_CLOCK_PIN,
    input  wire logic                  RECEIVE_CLOCK_PIN,
    input  wire logic                  TX_DATA,
    input  wire logic                  TXD_I,
    output logic                       TXD_O,
    output logic                       TXD_OE_N,
    input  wire logic                  CTS_N,
    input  wire logic                  CD_N,
    input  wire logic                  MODEM_DEDICATED,
    input  wire logic [7:0]            EVT_IN,
    input  wire logic [15:0]           TXBD_STATUS,
    input  wire logic                  TXBD_DONE,
    input  wire logic                  TX_ERROR,
    input  wire logic [15:0]           RXBD_STATUS,
    input  wire logic                  RXBD_DONE,
    input  wire logic                  RX_FRAME_END,
    input  wire logic [15:0]           RX_BYTE_CNT,
    output logic                       BRG_OUT,
    output logic                       TX_CLK,
    output logic                       RX_CLK,
    output logic [15:0]                MODE_CFG,
    output logic                       BYTE_SYNC,
    output logic                       TX_RUN,
    output logic                       RX_RUN,
    output logic                       RX_BUF_FULL,
    output logic                       RX_IDLE_FILL,
    output logic                       IRQ
);
    import chc_pkg::*;

    typedef struct packed {
        chc_axi_rsp_t  rsp;
        logic [AW-1:0] aw_addr;
        logic [31:0]   w_data;
        logic [3:0]    w_strb;
        logic [15:0]   clk_cfg;
        logic [15:0]   mode_cfg;
        logic [15:0]   ctl;
        logic [7:0]    ev;
        logic [7:0]    msk;
        logic [15:0]   rx_len;
        logic          tin_q;
        logic [1:0]    pre_cnt;
        logic [10:0]   div_cnt;
        logic          brg;
        logic          tx_clk;
        logic          rx_clk;
        logic          txd_o;
        logic          txd_oe_n;
        logic          cts_q;
        logic          cd_q;
        logic          tx_stop;
        logic          frame_done;
        logic          byte_sync;
        logic          tx_run;
        logic          rx_run;
        logic          rx_full;
        logic          idle_fill;
        logic          irq;
    } chc_state_t;

    localparam chc_state_t ST_RESET =
        '{rsp: RSP_RESET, txd_o: 1'b1, cts_q: 1'b1, cd_q: 1'b1, default: '0};

    chc_state_t s;
    chc_state_t next_s;

    // Merges a write into a 16-bit register under the two low byte strobes.
    function automatic logic [15:0] wmerge
    (
        input logic [15:0] old,
        input logic [31:0] d,
        input logic [3:0]  st
    );
        wmerge = {st[1] ? d[15:8] : old[15:8], st[0] ? d[7:0] : old[7:0]};
    endfunction

    // Returns the register index of an aligned in-range address, else all ones.
    function automatic logic [11:0] widx
    (
        input logic [AW-1:0] a
    );
        widx = (a[1:0] == 2'h0 && a[15:14] == 2'h0) ? a[13:2] : 12'hFFF;
    endfunction

    // Computes the whole next state: bus slave, baud generator and events.
    always_comb
    begin
        logic        src;
        logic        pre;
        logic        transp;
        logic        wr;
        logic [11:0] wi;
        logic [7:0]  set;
        logic [7:0]  clr;
        logic [7:0]  emsk;
        logic        stop_cmd;
        logic        restart_cmd;
        logic        cts_ok;
        logic        cd_ok;
        src = 1'b0;
        pre = 1'b0;
        transp = 1'b0;
        wr = 1'b0;
        wi = 12'hFFF;
        set = 8'h00;
        clr = 8'h00;
        emsk = 8'h00;
        stop_cmd = 1'b0;
        restart_cmd = 1'b0;
        cts_ok = 1'b1;
        cd_ok = 1'b1;
        next_s = s;

        // Write address and data are taken independently, in either order.
        if (AXI_REQ.awvalid && s.rsp.awready)
        begin
            next_s.aw_addr = AXI_REQ.awaddr;
            next_s.rsp.awready = 1'b0;
        end
        if (AXI_REQ.wvalid && s.rsp.wready)
        begin
            next_s.w_data = AXI_REQ.wdata;
            next_s.w_strb = AXI_REQ.wstrb;
            next_s.rsp.wready = 1'b0;
        end
        if (!s.rsp.awready && !s.rsp.wready && !s.rsp.bvalid)
        begin
            wr = 1'b1;
            wi = widx(s.aw_addr);
            next_s.rsp.bvalid = 1'b1;
            next_s.rsp.bresp = RSP_OK;
            case (wi)
                IDX_CLK: next_s.clk_cfg = wmerge(s.clk_cfg, s.w_data, s.w_strb);
                IDX_MODE:
                begin
                    // Reserved mode bit always reads as zero.
                    next_s.mode_cfg = wmerge(s.mode_cfg, s.w_data, s.w_strb) & MC_WMASK; // R7 R8
                end
                IDX_EVT: clr = s.w_strb[0] ? s.w_data[7:0] : 8'h00; // R9
                IDX_MSK:
                begin
                    if (s.w_strb[0])
                    begin
                        next_s.msk = s.w_data[7:0];
                    end
                end
                IDX_CTL:
                begin
                    if (s.w_strb[0])
                    begin
                        next_s.ctl[CT_NTS] = s.w_data[CT_NTS];
                        stop_cmd = s.w_data[CT_STOP];
                        restart_cmd = s.w_data[CT_RESTART];
                    end
                end
                IDX_RXL: next_s.rx_len = wmerge(s.rx_len, s.w_data, s.w_strb);
                IDX_STA: next_s.rsp.bresp = RSP_OK;
                default: next_s.rsp.bresp = RSP_ERR;
            endcase
        end
        if (s.rsp.bvalid && AXI_REQ.bready)
        begin
            next_s.rsp.bvalid = 1'b0;
            next_s.rsp.awready = 1'b1;
            next_s.rsp.wready = 1'b1;
        end

        // Reads answer one cycle after the address is taken.
        if (AXI_REQ.arvalid && s.rsp.arready)
        begin
            next_s.rsp.arready = 1'b0;
            next_s.rsp.rvalid = 1'b1;
            next_s.rsp.rresp = RSP_OK;
            next_s.rsp.rdata = 32'h0000_0000;
            case (widx(AXI_REQ.araddr))
                IDX_CLK: next_s.rsp.rdata[15:0] = s.clk_cfg;
                IDX_MODE: next_s.rsp.rdata[15:0] = s.mode_cfg;
                IDX_EVT: next_s.rsp.rdata[7:0] = s.ev;
                IDX_MSK: next_s.rsp.rdata[7:0] = s.msk;
                IDX_CTL: next_s.rsp.rdata[15:0] = {13'h0000, s.tx_stop, 1'b0, s.ctl[CT_NTS]};
                IDX_RXL: next_s.rsp.rdata[15:0] = s.rx_len;
                IDX_STA:
                begin
                    next_s.rsp.rdata[7:0] = {s.irq, s.byte_sync, s.idle_fill, s.rx_full,
                                             s.rx_run, s.tx_run, s.brg, TXD_I};
                end
                default: next_s.rsp.rresp = RSP_ERR;
            endcase
        end
        if (s.rsp.rvalid && AXI_REQ.rready)
        begin
            next_s.rsp.rvalid = 1'b0;
            next_s.rsp.arready = 1'b1;
        end

        // Generator source: every main clock cycle or each timer input rise.
        next_s.tin_q = TIMER_ONE_INPUT;
        src = s.clk_cfg[CC_EXT] ? (TIMER_ONE_INPUT & ~s.tin_q) : 1'b1; // R2
        if (src)
        begin
            if (s.clk_cfg[CC_PRESCALER_SELECT]) // R6
            begin
                next_s.pre_cnt = s.pre_cnt + 2'h1;
                pre = (s.pre_cnt == PRE_LAST);
            end
            else
            begin
                next_s.pre_cnt = 2'h0;
                pre = 1'b1;
            end
        end
        if (pre)
        begin
            if (s.div_cnt == 11'h000)
            begin
                next_s.div_cnt = s.clk_cfg[CC_CDH:CC_CDL]; // R5 R19
                next_s.brg = ~s.brg; // R19
            end
            else
            begin
                next_s.div_cnt = s.div_cnt - 11'h001; // R5
            end
        end
        next_s.tx_clk = s.clk_cfg[CC_TCS] ? TRANSMIT_CLOCK_PIN : s.brg; // R3
        next_s.rx_clk = s.clk_cfg[CC_RCS] ? RECEIVE_CLOCK_PIN : s.brg; // R4

        // Open-drain drives only the low level and releases for a one.
        if (s.clk_cfg[CC_OD])
        begin
            next_s.txd_o = 1'b0; // R1
            next_s.txd_oe_n = TX_DATA; // R1
        end
        else
        begin
            next_s.txd_o = TX_DATA;
            next_s.txd_oe_n = 1'b0;
        end

        // Transparent only while its mode is chosen and the no-sync bit is set.
        transp = (s.mode_cfg[1:0] == MODE_TRANSP) && s.ctl[CT_NTS];
        next_s.byte_sync = (s.mode_cfg[1:0] == MODE_TRANSP) && !s.ctl[CT_NTS]; // R16

        // Modem inputs gate the channel only under automatic loop control.
        if (s.mode_cfg[5:4] == LOOP_AUTO) // R17
        begin
            cts_ok = ~CTS_N;
            cd_ok = ~CD_N;
        end
        next_s.cts_q = CTS_N;
        next_s.cd_q = CD_N;

        // Event sources; a set in the same cycle as a clear wins.
        set = EVT_IN;
        set[EV_TX] = EVT_IN[EV_TX] | (TXBD_DONE & TXBD_STATUS[BD_INT]); // R13
        set[EV_RX] = EVT_IN[EV_RX] | (RXBD_DONE & RXBD_STATUS[BD_INT]); // R14
        set[EV_CTS] = EVT_IN[EV_CTS] | (MODEM_DEDICATED & (CTS_N ^ s.cts_q)); // R18
        set[EV_CD] = EVT_IN[EV_CD] | (MODEM_DEDICATED & (CD_N ^ s.cd_q)); // R18
        next_s.ev = (s.ev & ~clr) | set; // R9 R10

        // Mask gates the request only; bits five and three drop in transparent.
        emsk = s.msk;
        if (transp)
        begin
            emsk[EV_T5] = 1'b0; // R12
            emsk[EV_BS] = 1'b0; // R12
        end
        next_s.irq = |(s.ev & emsk); // R10

        // Stop or error halts transmit; restart resumes the current descriptor.
        if (stop_cmd || TX_ERROR)
        begin
            next_s.tx_stop = 1'b1;
        end
        else if (restart_cmd)
        begin
            next_s.tx_stop = 1'b0; // R20
        end
        next_s.tx_run = s.mode_cfg[MC_TE] & TXBD_STATUS[BD_RDY] & ~s.tx_stop & cts_ok; // R13
        next_s.rx_run = s.mode_cfg[MC_RE] & RXBD_STATUS[BD_RDY] & cd_ok;

        // Only receive buffers are bounded by the length limit.
        next_s.rx_full = (RX_BYTE_CNT >= s.rx_len); // R15

        // After frame end in transparent mode, further ready receive buffers fill with idles.
        if (!s.mode_cfg[MC_RE])
        begin
            next_s.frame_done = 1'b0;
        end
        else if (RX_FRAME_END)
        begin
            next_s.frame_done = 1'b1;
        end
        next_s.idle_fill = transp & s.frame_done & RXBD_STATUS[BD_RDY] & s.mode_cfg[MC_RE]; // R14
        if (wr && wi == IDX_STA)
        begin
            next_s.rsp.bresp = RSP_OK;
        end
    end

    // Registers the whole state.
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            s <= ST_RESET;
        end
        else
        begin
            s <= next_s;
        end
    end

    // Ports taken straight from state flip-flops.
    assign AXI_RSP = s.rsp;
    assign TXD_O = s.txd_o;
    assign TXD_OE_N = s.txd_oe_n;
    assign BRG_OUT = s.brg;
    assign TX_CLK = s.tx_clk;
    assign RX_CLK = s.rx_clk;
    assign MODE_CFG = s.mode_cfg;
    assign BYTE_SYNC = s.byte_sync;
    assign TX_RUN = s.tx_run;
    assign RX_RUN = s.rx_run;
    assign RX_BUF_FULL = s.rx_full;
    assign RX_IDLE_FILL = s.idle_fill;
    assign IRQ = s.irq;
endmodule // chc_top
`default_nettype wire
